// ==== bench/tb_top.sv ====
// self-checking bench for the uart rx block
`include "ubf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys_i, rst_i, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, rx_av, irq, line;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] div;
  logic [2:0] frac;
  int num_errors, checks;
  logic [33:0] exp_r[$];
  logic [1:0] exp_b[$];

  ubf_uart_rx i_ubf_uart_rx (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .rx_pin_i(line), .rx_available_o(rx_av), .irq_o(irq));
  ubf_peer_tx i_ubf_peer_tx (.clk_i(clk_sys_i), .div_i(div), .frac_i(frac), .line_o(line));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic give_verdict();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // answers are matched against the oldest note when their handshake completes
  always @(posedge clk_sys_i) begin
    if (rvalid === 1'b1 && rready === 1'b1) check({rresp, rdata}, exp_r.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1) check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
  end

  // bounded wait for a handshake signal sampled at a rising edge; sel picks aw, w, b, ar or r
  task automatic wait_for(input int sel);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (hit !== 1'b1 && n < 300) begin
      @(posedge clk_sys_i);
      n++;
      hit = (sel == 0) ? awready : (sel == 1) ? wready : (sel == 2) ? bvalid : (sel == 3) ? arready : rvalid;
    end
    if (hit !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // address and data may be taken on different edges
    fork
      begin
        wait_for(0);
        awvalid <= 1'b0;
      end
      begin
        wait_for(1);
        wvalid <= 1'b0;
      end
    join
    wait_for(2);
    bready <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_r.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    wait_for(3);
    arvalid <= 1'b0;
    wait_for(4);
    rready <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // lets the byte land in the fifo after the stop bit's last sample
  task automatic rx_byte(input logic [7:0] b);
    i_ubf_peer_tx.send(b);
    repeat (8) @(posedge clk_sys_i);
  endtask

  // flags are read as sampled at the edge the bus task ended on, settled a cycle before
  task automatic pins(input logic ef, input logic ei);
    check({32'h0, rx_av, irq}, {32'h0, ef, ef & ei});
  endtask

  initial begin
    logic [7:0] b[6];
    logic [15:0] dv;
    logic [2:0] fr;
    logic [7:0] fc;
    logic ef;
    rst_i = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    div = 16'h0010;
    frac = 3'h0;
    num_errors = 0;
    checks = 0;
    void'($urandom(6));
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    axi_rd(`UBF_OFS_FCTL, 32'h0, `UBF_RESP_OKAY);
    axi_rd(`UBF_OFS_FILL, 32'h0, `UBF_RESP_OKAY);
    axi_rd(8'h1C, 32'h0, `UBF_RESP_SLVERR);
    axi_wr(8'h20, 8'h00, `UBF_RESP_SLVERR);
    axi_wr(`UBF_OFS_FCTL, 8'hFF, `UBF_RESP_OKAY);
    axi_rd(`UBF_OFS_FCTL, 32'h3F, `UBF_RESP_OKAY);
    // pass 0: long bits, range clear, random fraction; pass 1: short bits, range set
    for (int p = 0; p < 2; p++) begin
      dv = p ? 16'h0008 : 16'h0010;
      fr = p ? 3'h7 : 3'($urandom);
      div <= dv;
      frac <= fr;
      axi_wr(`UBF_OFS_FCTL, {2'b0, fr, p[0], 2'b01}, `UBF_RESP_OKAY);
      axi_wr(`UBF_OFS_DIVL, dv[7:0], `UBF_RESP_OKAY);
      axi_wr(`UBF_OFS_DIVH, dv[15:8], `UBF_RESP_OKAY);
      axi_rd(`UBF_OFS_DIVH, {24'h0, dv[15:8]}, `UBF_RESP_OKAY);
      axi_wr(`UBF_OFS_CTRL, 8'h03, `UBF_RESP_OKAY);
      for (int i = 0; i < 6; i++) begin
        b[i] = 8'($urandom);
        rx_byte(b[i]);
        // every trigger code at fill levels one to four; range stays put
        for (int t = 0; i < 4 && t < 4; t++) begin
          axi_wr(`UBF_OFS_FCTL, {2'b0, fr, p[0], 2'(t)}, `UBF_RESP_OKAY);
          ef = (t == 0) ? (i == 3) : (i + 1 >= t);
          pins(ef, 1'b1);
          axi_rd(`UBF_OFS_STAT, {31'h0, ef}, `UBF_RESP_OKAY);
        end
        axi_rd(`UBF_OFS_FILL, (i < 4) ? i + 1 : 4, `UBF_RESP_OKAY);
      end
      // fifth byte was overwritten by the sixth, which moves in on the first pop
      for (int i = 0; i < 5; i++) begin
        axi_rd(`UBF_OFS_DATA, {24'h0, b[(i == 4) ? 5 : i]}, `UBF_RESP_OKAY);
        axi_rd(`UBF_OFS_FILL, (i == 0) ? 4 : 4 - i, `UBF_RESP_OKAY);
      end
      axi_rd(`UBF_OFS_DATA, 32'h0, `UBF_RESP_OKAY);
      // disable with data held: fifo and flags clear, settings kept
      rx_byte(8'($urandom));
      rx_byte(8'($urandom));
      fc = {2'b0, fr, p[0], 2'b01};
      axi_wr(`UBF_OFS_FCTL, fc, `UBF_RESP_OKAY);
      axi_wr(`UBF_OFS_CTRL, 8'h01, `UBF_RESP_OKAY);
      pins(1'b1, 1'b0);
      axi_wr(`UBF_OFS_CTRL, 8'h00, `UBF_RESP_OKAY);
      pins(1'b0, 1'b0);
      axi_rd(`UBF_OFS_FILL, 32'h0, `UBF_RESP_OKAY);
      axi_rd(`UBF_OFS_FCTL, {24'h0, fc}, `UBF_RESP_OKAY);
      axi_rd(`UBF_OFS_DIVL, {24'h0, dv[7:0]}, `UBF_RESP_OKAY);
    end
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== bench/ubf_peer_tx.sv ====
// remote serial peer that sends 8n1 frames with fractional bit timing
`timescale 1ns/1ps
`default_nettype none
module ubf_peer_tx (
  input wire logic clk_i, // bench clock
  input wire logic [15:0] div_i, // whole clocks per bit
  input wire logic [2:0] frac_i, // eighths of a clock added per bit
  output logic line_o // serial line, idle high
);
  logic [3:0] acc;
  // line rests high between frames, as a pulled-up idle line does
  initial begin
    line_o = 1'b1;
    acc = 4'h0;
  end
  // start bit, data lsb first, one stop bit; timing matches the device divider
  task automatic send(input logic [7:0] b);
    logic [9:0] fr;
    int len;
    fr = {1'b1, b, 1'b0};
    acc = 4'h0;
    for (int i = 0; i < 10; i++) begin
      len = div_i + (({1'b0, acc[2:0]} + {1'b0, frac_i}) > 7);
      acc = acc + {1'b0, frac_i};
      @(posedge clk_i);
      line_o <= fr[i];
      repeat (len - 1) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ==== rtl/ubf_baud_gen.sv ====
// bit timer with fractional accumulator and three sample strobes
`timescale 1ns/1ps
`default_nettype none
module ubf_baud_gen (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_i, // sync reset, high
  ubf_baud_if.gen bif // timing carrier
);
  logic [15:0] cnt;
  logic [3:0] acc;
  logic ext;
  logic [3:0] low_sum;
  logic [15:0] half;
  logic [15:0] p0;
  logic [15:0] p1;
  logic [15:0] p2;
  logic [15:0] len_cnt;

  // carry into bit 3 comes from the low three accumulator bits
  assign low_sum = {1'b0, acc[2:0]} + {1'b0, bif.frac};
  // bit ends after div cycles, plus one when the carry was seen
  assign bif.bit_end = ({1'b0, cnt} + 17'h00001) >= ({1'b0, bif.div} + {16'h0000, ext});
  // first two sample points move with the range select, the last does not
  assign half = bif.div >> 1;
  assign p0 = bif.range ? half - 16'h0001 : half;
  assign p1 = bif.range ? half : half + 16'h0001;
  assign p2 = half + 16'h0002;
  assign bif.smp = bif.run && !bif.restart && (cnt == p0 || cnt == p1);
  assign bif.smp_last = bif.run && !bif.restart && cnt == p2;

  // free running bit counter, realigned at each start edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !bif.run || bif.restart || bif.bit_end) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end

  // accumulator adds the fraction once per bit time
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !bif.run) begin
      acc <= 4'h0;
      ext <= 1'b0;
    end else if (bif.restart) begin
      acc <= {1'b0, bif.frac};
      ext <= 1'b0;
    end else if (bif.bit_end) begin
      acc <= acc + {1'b0, bif.frac};
      ext <= low_sum[3];
    end
  end

  // helper: cycles in the current bit, checked below
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !bif.run || bif.restart || bif.bit_end) begin
      len_cnt <= 16'h0001;
    end else begin
      len_cnt <= len_cnt + 16'h0001;
    end
  end

  a_bit_period: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bif.run && bif.bit_end && !bif.restart && bif.div >= 16'h0008) |-> len_cnt == bif.div + {15'h0000, ext})
    else $error("bit period differs from divisor plus carry");
  a_restart_acc: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bif.run && bif.restart) ##1 bif.run |-> acc == {1'b0, $past(bif.frac)} && !ext)
    else $error("accumulator not restarted at start bit");
  // a start edge in idle realigns the counter between strobes, so only unbroken runs are judged
  a_sample_span: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (bif.smp && !bif.range && cnt == half && bif.div >= 16'h0010) ##1 !bif.restart ##1 !bif.restart
      |-> $past(bif.smp) && bif.smp_last)
    else $error("sample strobes not on consecutive cycles");
  c_extra_cycle: cover property (@(posedge clk_sys_i) bif.bit_end && ext);
endmodule
`default_nettype wire

// ==== rtl/ubf_baud_if.sv ====
// carrier between receiver and baud generator
`timescale 1ns/1ps
`default_nettype none
interface ubf_baud_if;
  logic [15:0] div;
  logic [2:0] frac;
  logic range;
  logic run;
  logic restart;
  logic bit_end;
  logic smp;
  logic smp_last;
  modport gen (input div, frac, range, run, restart, output bit_end, smp, smp_last);
  modport rx (output div, frac, range, run, restart, input bit_end, smp, smp_last);
endinterface
`default_nettype wire

// ==== rtl/ubf_defines.svh ====
// register offsets, field positions and reset values of the uart rx block
`ifndef UBF_DEFINES_SVH
`define UBF_DEFINES_SVH
`define UBF_OFS_CTRL 8'h00
`define UBF_OFS_FCTL 8'h04
`define UBF_OFS_DIVL 8'h08
`define UBF_OFS_DIVH 8'h0C
`define UBF_OFS_DATA 8'h10
`define UBF_OFS_FILL 8'h14
`define UBF_OFS_STAT 8'h18
`define UBF_EN_BIT 0
`define UBF_IRQEN_BIT 1
`define UBF_FRAC_MSB 5
`define UBF_FRAC_LSB 3
`define UBF_RANGE_BIT 2
`define UBF_TRIG_MSB 1
`define UBF_TRIG_LSB 0
`define UBF_CTRL_RST 2'h0
`define UBF_FCTL_RST 6'h00
`define UBF_DIV_RST 16'h0000
`define UBF_DIVL_RST 8'h00
`define UBF_FIFO_DEPTH 3'h4
`define UBF_RESP_OKAY 2'h0
`define UBF_RESP_SLVERR 2'h2
`endif

// ==== rtl/ubf_pkg.sv ====
// types shared by the uart rx block
package ubf_pkg;
  typedef enum logic [3:0] {
    UBF_IDLE = 4'h1,
    UBF_START = 4'h2,
    UBF_DATA = 4'h4,
    UBF_STOP = 4'h8
  } ubf_rx_state_e;
  typedef logic [7:0] ubf_byte_t;
endpackage

// ==== rtl/ubf_uart_rx.sv ====
// uart rx core: axi4-lite registers, receiver, four byte fifo
//
// Operation
// - three bit fraction tunes rx timing
// - fraction added to accumulator every bit time
// - carry into bit 3 adds one clock
// - free running 16-bit bit timer
// - baud equals clock over divisor plus fraction/8
// - range clear samples at half, +1, +2
// - range set samples at half-1, half, +2
// - two bit code picks trigger fill level
// - trigger sets flag, irq when enabled
// - fifo empty after reset
// - read only three bit fill counter
// - counter counts pushes up and reads down
// - four bytes held, one extra waits in shifter
// - fill counter cleared by reset and disable
// - unimplemented bits read as zero
// - unit disable empties fifo, keeps settings
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`include "ubf_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ubf_uart_rx (
  input wire logic clk_sys_i, // 100 MHz clock
  input wire logic rst_i, // sync reset, high
  input wire logic [7:0] s_axi_awaddr_i, // write address
  input wire logic s_axi_awvalid_i, // write address valid
  output logic s_axi_awready_o, // write address ready
  input wire logic [31:0] s_axi_wdata_i, // write data
  input wire logic [3:0] s_axi_wstrb_i, // write strobes
  input wire logic s_axi_wvalid_i, // write data valid
  output logic s_axi_wready_o, // write data ready
  output logic [1:0] s_axi_bresp_o, // write response
  output logic s_axi_bvalid_o, // write response valid
  input wire logic s_axi_bready_i, // write response ready
  input wire logic [7:0] s_axi_araddr_i, // read address
  input wire logic s_axi_arvalid_i, // read address valid
  output logic s_axi_arready_o, // read address ready
  output logic [31:0] s_axi_rdata_o, // read data
  output logic [1:0] s_axi_rresp_o, // read response
  output logic s_axi_rvalid_o, // read data valid
  input wire logic s_axi_rready_i, // read data ready
  input wire logic rx_pin_i, // serial line in
  output logic rx_available_o, // rx available flag
  output logic irq_o // uart interrupt request
);
  logic [1:0] ctrl;
  logic [5:0] fctl;
  logic [7:0] div_low_stage;
  logic [15:0] div;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_got;
  logic w_got;
  logic wr_do;
  logic rd_take;
  logic rd_pop;
  logic unit_en;
  logic irq_en;
  logic [2:0] rx_sync;
  logic rx_line;
  ubf_pkg::ubf_rx_state_e st;
  logic [1:0] votes;
  logic bit_val;
  logic [2:0] bit_idx;
  ubf_pkg::ubf_byte_t shifter;
  logic rx_done;
  ubf_pkg::ubf_byte_t rx_byte;
  ubf_pkg::ubf_byte_t mem [4];
  logic [1:0] wp;
  logic [1:0] rp;
  logic [2:0] fill;
  logic [2:0] next_fill;
  logic held_v;
  ubf_pkg::ubf_byte_t held_b;
  logic in_avail;
  ubf_pkg::ubf_byte_t in_data;
  logic push_fifo;
  logic pop;
  logic [1:0] trig;
  logic meets_next;
  ubf_baud_if bif ();

  assign unit_en = ctrl[`UBF_EN_BIT];
  assign irq_en = ctrl[`UBF_IRQEN_BIT];
  assign trig = fctl[`UBF_TRIG_MSB:`UBF_TRIG_LSB];

  // baud generator wiring; range and fraction go straight from the register
  assign bif.div = div;
  assign bif.frac = fctl[`UBF_FRAC_MSB:`UBF_FRAC_LSB];
  assign bif.range = fctl[`UBF_RANGE_BIT];
  assign bif.run = unit_en;
  assign bif.restart = st == ubf_pkg::UBF_IDLE && !rx_line && unit_en;

  ubf_baud_gen u_baud (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .bif(bif)
  );

  // axi write: address and data are taken in either order
  assign wr_do = aw_got && w_got && !s_axi_bvalid_o;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      aw_got <= 1'b0;
      aw_addr <= 8'h00;
      s_axi_awready_o <= 1'b0;
    end else if (s_axi_awready_o && s_axi_awvalid_i) begin
      aw_got <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
      s_axi_awready_o <= 1'b0;
    end else if (wr_do) begin
      aw_got <= 1'b0;
    end else if (!aw_got && !s_axi_bvalid_o) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      w_got <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_wready_o <= 1'b0;
    end else if (s_axi_wready_o && s_axi_wvalid_i) begin
      w_got <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
      s_axi_wready_o <= 1'b0;
    end else if (wr_do) begin
      w_got <= 1'b0;
    end else if (!w_got && !s_axi_bvalid_o) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `UBF_RESP_OKAY;
    end else if (wr_do) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= (aw_addr > `UBF_OFS_STAT || aw_addr[1:0] != 2'h0) ? `UBF_RESP_SLVERR : `UBF_RESP_OKAY;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // register writes; high byte commits the staged low byte as one word
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl <= `UBF_CTRL_RST;
      fctl <= `UBF_FCTL_RST;
      div_low_stage <= `UBF_DIVL_RST;
      div <= `UBF_DIV_RST;
    end else if (wr_do && w_strb[0]) begin
      unique case (aw_addr)
        `UBF_OFS_CTRL: ctrl <= w_data[1:0];
        `UBF_OFS_FCTL: fctl <= w_data[5:0];
        `UBF_OFS_DIVL: div_low_stage <= w_data[7:0];
        `UBF_OFS_DIVH: div <= {w_data[7:0], div_low_stage};
        default: ;
      endcase
    end
  end

  // axi read; a read of the data word pops one byte
  assign rd_take = s_axi_arready_o && s_axi_arvalid_i;
  assign rd_pop = rd_take && s_axi_araddr_i == `UBF_OFS_DATA;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= `UBF_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= `UBF_RESP_OKAY;
      unique case (s_axi_araddr_i)
        `UBF_OFS_CTRL: s_axi_rdata_o <= {30'h00000000, ctrl};
        `UBF_OFS_FCTL: s_axi_rdata_o <= {26'h0000000, fctl};
        `UBF_OFS_DIVL: s_axi_rdata_o <= {24'h000000, div_low_stage};
        `UBF_OFS_DIVH: s_axi_rdata_o <= {24'h000000, div[15:8]};
        `UBF_OFS_DATA: s_axi_rdata_o <= {24'h000000, fill != 3'h0 ? mem[rp] : 8'h00};
        `UBF_OFS_FILL: s_axi_rdata_o <= {29'h00000000, fill};
        `UBF_OFS_STAT: s_axi_rdata_o <= {30'h00000000, st != ubf_pkg::UBF_IDLE, rx_available_o};
        default: begin
          s_axi_rdata_o <= 32'h00000000;
          s_axi_rresp_o <= `UBF_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end else if (!s_axi_rvalid_o) begin
      s_axi_arready_o <= 1'b1;
    end
  end

  // line synchroniser; the level moves once stages two and three agree
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_sync <= 3'h7;
      rx_line <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], rx_pin_i};
      if (rx_sync[1] == rx_sync[2]) begin
        rx_line <= rx_sync[2];
      end
    end
  end

  // majority of the three samples decides the bit
  assign bit_val = ({1'b0, votes} + {2'h0, rx_line}) >= 3'h2;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || bif.restart || bif.smp_last) begin
      votes <= 2'h0;
    end else if (bif.smp && rx_line) begin
      votes <= votes + 2'h1;
    end
  end

  // frame receiver: start, eight data bits lsb first, one stop bit
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !unit_en) begin
      st <= ubf_pkg::UBF_IDLE;
      bit_idx <= 3'h0;
      shifter <= 8'h00;
      rx_done <= 1'b0;
      rx_byte <= 8'h00;
    end else begin
      rx_done <= 1'b0;
      unique case (st)
        ubf_pkg::UBF_IDLE: begin
          bit_idx <= 3'h0;
          if (!rx_line) begin
            st <= ubf_pkg::UBF_START;
          end
        end
        ubf_pkg::UBF_START: begin
          if (bif.smp_last) begin
            st <= bit_val ? ubf_pkg::UBF_IDLE : ubf_pkg::UBF_DATA; // glitch rejected
          end
        end
        ubf_pkg::UBF_DATA: begin
          if (bif.smp_last) begin
            shifter <= {bit_val, shifter[7:1]};
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == 3'h7) begin
              st <= ubf_pkg::UBF_STOP;
            end
          end
        end
        ubf_pkg::UBF_STOP: begin
          // byte is kept even on a bad stop bit; no framing flag here
          if (bif.smp_last) begin
            rx_done <= 1'b1;
            rx_byte <= shifter;
            st <= ubf_pkg::UBF_IDLE;
          end
        end
      endcase
    end
  end

  // a waiting byte in the shifter has priority over a fresh one
  assign pop = rd_pop && fill != 3'h0;
  assign in_avail = held_v || rx_done;
  assign in_data = held_v ? held_b : rx_byte;
  assign push_fifo = in_avail && (fill < `UBF_FIFO_DEPTH || pop);
  assign next_fill = fill + {2'h0, push_fifo} - {2'h0, pop};

  // fill count and pointers; disable empties like reset does
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !unit_en) begin
      fill <= 3'h0;
      wp <= 2'h0;
      rp <= 2'h0;
    end else begin
      fill <= next_fill;
      wp <= wp + {1'b0, push_fifo};
      rp <= rp + {1'b0, pop};
    end
  end

  // fifth byte waits in the shifter, a sixth overwrites it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !unit_en) begin
      held_v <= 1'b0;
      held_b <= 8'h00;
    end else if (rx_done && !(push_fifo && !held_v)) begin
      held_v <= 1'b1;
      held_b <= rx_byte;
    end else if (push_fifo && held_v) begin
      held_v <= 1'b0;
    end
  end

  // storage, one writer per entry
  for (genvar gi = 0; gi < 4; gi++) begin : g_mem
    always_ff @(posedge clk_sys_i) begin
      if (push_fifo && wp == 2'(gi)) begin
        mem[gi] <= in_data;
      end
    end
  end

  // trigger code 00 asks for a full fifo, others for that many or more
  assign meets_next = trig == 2'h0 ? next_fill == `UBF_FIFO_DEPTH : next_fill >= {1'b0, trig};
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !unit_en) begin
      rx_available_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      rx_available_o <= meets_next;
      irq_o <= meets_next && irq_en;
    end
  end

  a_fill_limit: assert property (@(posedge clk_sys_i) disable iff (rst_i) fill <= `UBF_FIFO_DEPTH)
    else $error("fill count above four");
  a_fill_incr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (unit_en && push_fifo && !pop) ##1 unit_en |-> fill == $past(fill) + 3'h1)
    else $error("fill count did not rise on push");
  a_fill_decr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (unit_en && pop && !push_fifo) ##1 unit_en |-> fill == $past(fill) - 3'h1)
    else $error("fill count did not fall on read");
  a_disable_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !unit_en |=> fill == 3'h0 && !rx_available_o && !held_v && !irq_o)
    else $error("disable left receive state behind");
  a_held_full: assert property (@(posedge clk_sys_i) disable iff (rst_i) held_v |-> fill == `UBF_FIFO_DEPTH)
    else $error("byte waits while fifo has room");
  a_flag_level: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $past(unit_en) |-> rx_available_o == (trig == 2'h0 ? fill == 3'h4 : fill >= {1'b0, trig}) || $changed(fctl))
    else $error("available flag disagrees with trigger level");
  a_irq_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    irq_o |-> rx_available_o && $past(irq_en))
    else $error("interrupt without enable or flag");
  a_reset_empty: assert property (@(posedge clk_sys_i) $fell(rst_i) |-> fill == 3'h0)
    else $error("fifo not empty after reset");
  c_byte_rx: cover property (@(posedge clk_sys_i) disable iff (rst_i) rx_done);
  c_full_wait: cover property (@(posedge clk_sys_i) disable iff (rst_i) held_v && rx_done);
  c_flag_rise: cover property (@(posedge clk_sys_i) disable iff (rst_i) $rose(rx_available_o) && trig == 2'h2);
  c_pop: cover property (@(posedge clk_sys_i) disable iff (rst_i) pop && held_v);
endmodule
`default_nettype wire
